// file: include/sbgp_pkg.sv
// Constants, types and helpers for the standby GPIO event port
package sbgp_pkg;
    localparam int CLK_NS = 100;
    localparam int TICK_NS = 1_000_000;
    localparam int TICK_CYC = TICK_NS / CLK_NS;
    localparam int DEB_MS = 15;
    localparam int DEB_TICKS = DEB_MS * 1_000_000 / TICK_NS;
    localparam int NPIN = 12;
    localparam int NEV = 8;
    localparam int N_BIDIR = 6;
    localparam int P1_BASE = 8;
    localparam int N_OUTP = 2;
    localparam int SEL_PORT = 4;
    localparam int CB_OE = 0;
    localparam int CB_OT = 1;
    localparam int CB_PU = 2;
    localparam int CB_LOCK = 3;
    localparam int CB_TYPE = 4;
    localparam int CB_POL = 5;
    localparam int CB_DEB = 6;
    localparam logic [7:0] OFF_SEL = 8'h13;
    localparam logic [7:0] OFF_CFG = 8'h14;
    localparam logic [7:0] OFF_DO0 = 8'h00;
    localparam logic [7:0] OFF_DI0 = 8'h01;
    localparam logic [7:0] OFF_DO1 = 8'h02;
    localparam logic [7:0] OFF_DI1 = 8'h03;
    localparam logic [7:0] SEL_MASK = 8'h17;
    localparam logic [7:0] RST_SEL = 8'h00;
    localparam logic [7:0] RST_DOUT = 8'hFF;
    localparam logic [7:0] RST_BIDIR = 8'h44;
    localparam logic [7:0] RST_EVIN = 8'h40;
    localparam logic [7:0] RST_OUTP = 8'h05;
    localparam logic [7:0] RST_NONE = 8'h00;
    localparam logic [7:0] WM_BIDIR = 8'h7F;
    localparam logic [7:0] WM_EVIN = 8'h70;
    localparam logic [7:0] WM_OUTP = 8'h0E;
    localparam logic [7:0] WM_LOCKED = 8'h70;

    typedef struct packed {
        logic rt;
        logic rd;
        logic wr;
        logic [7:0] addr;
        logic [7:0] wdata;
    } sbgp_req_s;

    typedef struct packed {
        logic [NPIN-1:0] drv;
        logic [NPIN-1:0] oe;
        logic [NPIN-1:0] pu;
    } sbgp_pad_s;

    typedef struct packed {
        logic prev;
        logic deb;
        logic [3:0] cnt;
        logic ev;
    } sbgp_ev_s;

    typedef struct packed {
        logic [7:0] sel;
        logic [NPIN-1:0][7:0] cfg;
        logic [1:0][7:0] dout;
        logic [NPIN-1:0] s1;
        logic [NPIN-1:0] s2;
        logic [7:0] rdata;
        logic rvalid;
        sbgp_pad_s pad;
    } sbgp_top_s;

    typedef struct packed {
        logic [15:0] cnt;
        logic tick;
    } sbgp_tick_s;

    function automatic logic [7:0] sbgp_cfg_rst(input int idx);
        if (idx < N_BIDIR) return RST_BIDIR;
        if (idx < NEV) return RST_EVIN;
        if (idx < P1_BASE + N_OUTP) return RST_OUTP;
        return RST_NONE;
    endfunction

    function automatic logic [7:0] sbgp_cfg_wmask(input int idx);
        if (idx < N_BIDIR) return WM_BIDIR;
        if (idx < NEV) return WM_EVIN;
        if (idx < P1_BASE + N_OUTP) return WM_OUTP;
        return RST_NONE;
    endfunction
endpackage

// file: logic/sbgp_tick.sv
// Slow standby tick divider feeding the debouncers
module sbgp_tick import sbgp_pkg::*; #(
    parameter int CYCLES = TICK_CYC
) (
    // Clock and reset
    input wire logic clock,
    input wire logic rst,
    // Slow tick
    output logic tick
);
    sbgp_tick_s st_q, st_d;

    always_comb begin
        st_d = st_q;
        st_d.tick = 1'b0;
        if (st_q.cnt == 16'(CYCLES - 1)) begin
            st_d.cnt = 16'h0000;
            st_d.tick = 1'b1;
        end else begin
            st_d.cnt = st_q.cnt + 16'h0001;
        end
        if (rst) begin
            st_d = '0;
        end
    end

    always_ff @(posedge clock) begin
        st_q <= st_d;
    end

    assign tick = st_q.tick;

    tick_period_a: assert property (@(posedge clock) disable iff (rst)
        st_q.tick |=> !st_q.tick)
        else $error("tick longer than one cycle");
endmodule

// file: logic/sbgp_event.sv
// Debouncer and edge or level detector for one event pin
module sbgp_event import sbgp_pkg::*; (
    // Clock and reset
    input wire logic clock,
    input wire logic rst,
    input wire logic tick,
    // Synchronised pin level and setup bits
    input wire logic level,
    input wire logic deb_en,
    input wire logic lvl_type,
    input wire logic pol,
    // Event indicator
    output logic ev
);
    sbgp_ev_s st_q, st_d;
    logic det;

    always_comb begin
        st_d = st_q;
        // Counter only runs while level differs from settled value
        if (level == st_q.deb) begin
            st_d.cnt = 4'h0;
        end else if (tick) begin
            if (st_q.cnt == 4'(DEB_TICKS - 1)) begin
                st_d.deb = level;
                st_d.cnt = 4'h0;
            end else begin
                st_d.cnt = st_q.cnt + 4'h1;
            end
        end
        det = deb_en ? st_q.deb : level;
        st_d.prev = det;
        if (lvl_type) begin
            st_d.ev = (det == pol);
        end else begin
            st_d.ev = (det != st_q.prev) && (det == pol);
        end
        if (rst) begin
            st_d = '0;
            st_d.prev = 1'b1;
            st_d.deb = 1'b1;
        end
    end

    always_ff @(posedge clock) begin
        st_q <= st_d;
    end

    assign ev = st_q.ev;

    default clocking @(posedge clock); endclocking
    default disable iff (rst);

    sequence s_settle;
        deb_en && tick && level != st_q.deb &&
            st_q.cnt == 4'(DEB_TICKS - 1);
    endsequence

    deb_settle_a: assert property (s_settle |=> st_q.deb == $past(level))
        else $error("debounced level not taken after wait");
    deb_hold_a: assert property (!(tick && level != st_q.deb)
        |=> $stable(st_q.deb))
        else $error("debounced level moved without tick");
    edge_pulse_a: assert property (!lvl_type && ev && !$past(lvl_type)
        |=> !ev || lvl_type)
        else $error("edge event longer than one cycle");
    level_ev_a: assert property (lvl_type && !deb_en && $stable(pol)
        |=> ev == ($past(level) == $past(pol)))
        else $error("level event does not follow pin");
endmodule

// file: logic/sbgp_top.sv
// Standby GPIO port: pin setup, runtime data and event detection
module sbgp_top import sbgp_pkg::*; #(
    parameter int TICK_CYCLES = TICK_CYC
) (
    // Clock and reset
    input wire logic clock,
    input wire logic rst,
    // Register access
    input wire sbgp_req_s req,
    input wire logic wake_active,
    output logic [7:0] rdata,
    output logic rvalid,
    // Pins: port 0 bits 0-7 then port 1 bits 0-3
    input wire logic [NPIN-1:0] pin_in,
    output sbgp_pad_s pad,
    // Wake controller status events
    output logic [NEV-1:0] wake_event
);
    sbgp_top_s st_q, st_d;
    logic tick;
    logic [3:0] idx;
    logic idx_ok;
    logic [7:0] cur;
    logic [7:0] wm;
    logic [7:0] nw;
    logic dv;
    logic cfg_wr;
    logic rt_wr;
    logic rt_rd;

    function automatic logic [7:0] lock_mask(
        input logic [NPIN-1:0][7:0] c, input int port);
        logic [7:0] m;
        int i;
        m = 8'h00;
        for (i = 0; i < 8; i++) begin
            if (port == 0) begin
                m[i] = c[i][CB_LOCK];
            end else if (i < NPIN - P1_BASE) begin
                m[i] = c[P1_BASE + i][CB_LOCK];
            end
        end
        return m;
    endfunction

    sbgp_tick #(
        .CYCLES(TICK_CYCLES)
    ) u_tick (
        .clock(clock),
        .rst(rst),
        .tick(tick)
    );

    for (genvar g = 0; g < NEV; g++) begin : g_ev
        sbgp_event u_ev (
            .clock(clock),
            .rst(rst),
            .tick(tick),
            .level(st_q.s2[g]),
            .deb_en(st_q.cfg[g][CB_DEB]),
            .lvl_type(st_q.cfg[g][CB_TYPE]),
            .pol(st_q.cfg[g][CB_POL]),
            .ev(wake_event[g])
        );
    end

    always_comb begin
        st_d = st_q;
        // Index decode: port 1 reaches only its two output pins
        idx = st_q.sel[SEL_PORT] ? 4'(P1_BASE) + {1'b0, st_q.sel[2:0]}
                                 : {1'b0, st_q.sel[2:0]};
        idx_ok = !st_q.sel[SEL_PORT] ||
                 (st_q.sel[2:0] < 3'(N_OUTP));
        cur = idx_ok ? st_q.cfg[idx] : 8'h00;
        wm = idx_ok ? sbgp_cfg_wmask(int'(idx)) : 8'h00;
        if (cur[CB_LOCK]) begin
            wm = wm & WM_LOCKED;
        end
        nw = (cur & ~wm) | (req.wdata & wm);
        nw[CB_LOCK] = cur[CB_LOCK] | (req.wdata[CB_LOCK] & wm[CB_LOCK]);
        cfg_wr = req.wr && !req.rt;
        rt_wr = req.wr && req.rt && wake_active;
        rt_rd = req.rd && req.rt && wake_active;

        // Two-stage resync; only the second stage is used
        st_d.s1 = pin_in;
        st_d.s2 = st_q.s1;

        if (cfg_wr && req.addr == OFF_SEL) begin
            st_d.sel = req.wdata & SEL_MASK;
        end
        if (cfg_wr && req.addr == OFF_CFG && idx_ok) begin
            st_d.cfg[idx] = nw;
        end
        if (rt_wr && req.addr == OFF_DO0) begin
            st_d.dout[0] = (st_q.dout[0] & lock_mask(st_q.cfg, 0)) |
                (req.wdata & ~lock_mask(st_q.cfg, 0));
        end
        if (rt_wr && req.addr == OFF_DO1) begin
            st_d.dout[1] = (st_q.dout[1] & lock_mask(st_q.cfg, 1)) |
                (req.wdata & ~lock_mask(st_q.cfg, 1));
        end

        // Read answer one cycle after the strobe
        st_d.rvalid = req.rd;
        st_d.rdata = 8'h00;
        if (req.rd && !req.rt) begin
            case (req.addr)
                OFF_SEL: st_d.rdata = st_q.sel;
                OFF_CFG: st_d.rdata = cur;
                default: st_d.rdata = 8'h00;
            endcase
        end else if (rt_rd) begin
            case (req.addr)
                OFF_DO0: st_d.rdata = st_q.dout[0];
                OFF_DO1: st_d.rdata = st_q.dout[1];
                OFF_DI0: st_d.rdata = st_q.s2[7:0];
                OFF_DI1: st_d.rdata = {4'h0, st_q.s2[NPIN-1:P1_BASE]};
                default: st_d.rdata = 8'h00;
            endcase
        end

        // Pad drive; open-drain only ever pulls low
        for (int i = 0; i < NPIN; i++) begin
            dv = (i < P1_BASE) ? st_q.dout[0][i % 8]
                               : st_q.dout[1][i % 8];
            st_d.pad.oe[i] = st_q.cfg[i][CB_OE] &
                (st_q.cfg[i][CB_OT] | ~dv);
            st_d.pad.drv[i] = dv & st_q.cfg[i][CB_OT];
            st_d.pad.pu[i] = st_q.cfg[i][CB_PU];
        end

        if (rst) begin
            st_d = '0;
            st_d.sel = RST_SEL;
            st_d.dout[0] = RST_DOUT;
            st_d.dout[1] = RST_DOUT;
            for (int i = 0; i < NPIN; i++) begin
                st_d.cfg[i] = sbgp_cfg_rst(i);
            end
        end
    end

    always_ff @(posedge clock) begin
        st_q <= st_d;
    end

    assign rdata = st_q.rdata;
    assign rvalid = st_q.rvalid;
    assign pad = st_q.pad;

    default clocking @(posedge clock); endclocking
    default disable iff (rst);

    sequence s_cfg_wr_locked;
        cfg_wr && req.addr == OFF_CFG && idx_ok && cur[CB_LOCK];
    endsequence

    sequence s_rd_pins0;
        req.rd && req.rt && wake_active && req.addr == OFF_DI0;
    endsequence

    cfg_lock_a: assert property (s_cfg_wr_locked
        |=> st_q.cfg[$past(idx)][3:0] == $past(cur[3:0]))
        else $error("locked setup bits changed");
    dout_lock_a: assert property (##1 ((st_q.dout[0] ^
        $past(st_q.dout[0])) & $past(lock_mask(st_q.cfg, 0))) == 8'h00)
        else $error("locked output bit changed");
    inactive_a: assert property (!wake_active |=> $stable(st_q.dout)
        && (!$past(req.rt) || st_q.rdata == 8'h00))
        else $error("runtime access while inactive");
    pin_level_a: assert property (s_rd_pins0
        |=> rvalid && rdata == $past(pin_in[7:0], 3))
        else $error("pin level read wrong");
    od_high_a: assert property (##1 !(pad.oe[0] && pad.drv[0] &&
        !$past(st_q.cfg[0][CB_OT])))
        else $error("open-drain pin driven high");
    oe_cause_a: assert property (##1 pad.oe[0] |->
        $past(st_q.cfg[0][CB_OE]))
        else $error("driver on without direction bit");
    outp_bit0_a: assert property (req.rd && !req.rt &&
        req.addr == OFF_CFG && st_q.sel == 8'h10
        |=> rdata[CB_OE])
        else $error("output-only pin bit 0 not one");
    sel_reset_a: assert property (@(posedge clock) disable iff (1'b0)
        rst |=> st_q.sel == RST_SEL)
        else $error("pin index not cleared by reset");
    dout_read_a: assert property (req.rd && req.rt && wake_active &&
        req.addr == OFF_DO0 |=> rdata == $past(st_q.dout[0]))
        else $error("output register read wrong");
endmodule

// file: sim/sbgp_board.sv
// Board-side model of the standby pins
module sbgp_board import sbgp_pkg::*; (
    // Clock
    input wire logic clock,
    // Device pads and board drive
    input wire sbgp_pad_s pad,
    input wire logic [NPIN-1:0] ext_en,
    input wire logic [NPIN-1:0] ext_val,
    // Pin levels seen by the device
    output logic [NPIN-1:0] pin_in
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [NPIN-1:0] flt = '0;
    // Floating pins wander so no stale level passes for a real one
    always @(posedge clock) flt <= ~flt;
    always_comb begin
        for (int i = 0; i < NPIN; i++) begin
            if (pad.oe[i]) pin_in[i] = pad.drv[i];
            else if (ext_en[i]) pin_in[i] = ext_val[i];
            else pin_in[i] = pad.pu[i] ? 1'b1 : flt[i];
        end
    end
endmodule

// file: sim/tb_sbgp_top.sv
// Self-checking bench for the standby GPIO event port
module tb_sbgp_top import sbgp_pkg::*;;
    timeunit 1ns;
    timeprecision 1ns;
    localparam int TK = 4;
    logic clock = 0;
    logic rst = 1;
    sbgp_req_s req = '0;
    logic wake_active = 1;
    logic [7:0] rdata;
    logic rvalid;
    logic [NPIN-1:0] pin_in;
    logic [NPIN-1:0] ext_en = '1;
    logic [NPIN-1:0] ext_val = '1;
    sbgp_pad_s pad;
    logic [NEV-1:0] wake_event;
    int miscompares = 0;
    int cmp_count = 0;
    logic [7:0] q;
    int n;
    always #50 clock = ~clock;
    sbgp_top #(.TICK_CYCLES(TK)) sbgp_top_i (.clock(clock), .rst(rst),
        .req(req), .wake_active(wake_active), .rdata(rdata),
        .rvalid(rvalid), .pin_in(pin_in), .pad(pad),
        .wake_event(wake_event));
    sbgp_board sbgp_board_i (.clock(clock), .pad(pad), .ext_en(ext_en),
        .ext_val(ext_val), .pin_in(pin_in));

    task automatic chk(input string s, input logic [7:0] e, g);
        cmp_count++;
        if (g !== e) begin
            miscompares++;
            $display("mismatch %s expected %h seen %h", s, e, g);
        end
    endtask

    task automatic acc(input logic rt, w, input logic [7:0] a, d);
        @(posedge clock);
        req <= '{rt, !w, w, a, d};
        @(posedge clock);
        req <= '0;
        #1;
        q = rdata;
        if (!w) chk("rvalid", 8'h01, {7'h00, rvalid});
    endtask

    task automatic wr(input logic rt, input logic [7:0] a, d);
        acc(rt, 1'b1, a, d);
    endtask

    task automatic rd(input string s, input logic rt,
                      input logic [7:0] a, e);
        acc(rt, 1'b0, a, 8'h00);
        chk(s, e, q);
    endtask

    task automatic settle;
        repeat (4) @(posedge clock);
        #1;
    endtask

    // Cycles until event 6 shows v, capped at lim
    task automatic wait_ev(input int lim, input logic v);
        n = 0;
        while (wake_event[6] !== v && n < lim) begin
            @(posedge clock);
            #1;
            n++;
        end
    endtask

    task automatic t_reset;
        rd("index", 0, OFF_SEL, 8'h00);
        rd("setup0", 0, OFF_CFG, 8'h44);
        rd("out0", 1, OFF_DO0, 8'hFF);
        chk("oe0", 8'h00, {7'h00, pad.oe[0]});
    endtask

    task automatic t_drive;
        ext_val[0] <= 1'b0;
        wr(1, OFF_DO0, 8'h01);
        wr(0, OFF_CFG, 8'h47);
        settle();
        rd("lvl pp", 1, OFF_DI0, 8'hFF);
        wr(1, OFF_DI0, 8'h00);
        rd("lvl ro", 1, OFF_DI0, 8'hFF);
        wr(0, OFF_CFG, 8'h45);
        settle();
        rd("lvl od", 1, OFF_DI0, 8'hFE);
        ext_en[0] <= 1'b0;
        settle();
        rd("lvl pu", 1, OFF_DI0, 8'hFF);
        rd("out0", 1, OFF_DO0, 8'h01);
    endtask

    task automatic t_lock;
        wr(0, OFF_CFG, 8'h4F);
        wr(0, OFF_CFG, 8'h30);
        rd("locked", 0, OFF_CFG, 8'h3F);
        wr(1, OFF_DO0, 8'hFE);
        rd("out lock", 1, OFF_DO0, 8'hFF);
        wr(0, OFF_SEL, 8'hFF);
        rd("index", 0, OFF_SEL, 8'h17);
        rd("no setup", 0, OFF_CFG, 8'h00);
        wr(0, OFF_SEL, 8'h10);
        rd("outp rst", 0, OFF_CFG, 8'h05);
        wr(0, OFF_CFG, 8'h00);
        rd("outp oe", 0, OFF_CFG, 8'h01);
        rd("lvl1", 1, OFF_DI1, 8'h0F);
    endtask

    task automatic t_inactive;
        wake_active <= 1'b0;
        wr(1, OFF_DO0, 8'h00);
        rd("blocked", 1, OFF_DO0, 8'h00);
        chk("drv0", 8'h01, {7'h00, pad.drv[0]});
        wake_active <= 1'b1;
        rd("kept", 1, OFF_DO0, 8'hFF);
    endtask

    task automatic t_events;
        logic [7:0] cf [4] = '{8'h00, 8'h20, 8'h10, 8'h30};
        wr(0, OFF_SEL, 8'h06);
        foreach (cf[i]) begin
            ext_val[6] <= !cf[i][5];
            wr(0, OFF_CFG, cf[i]);
            settle();
            chk("idle", 8'h00, {7'h00, wake_event[6]});
            ext_val[6] <= cf[i][5];
            wait_ev(10, 1'b1);
            chk("lag", 8'h01, {7'h00, n inside {[2:4]}});
            settle();
            chk("hold", {7'h00, cf[i][4]}, {7'h00, wake_event[6]});
        end
        // Debounced high level: glitch, then assert and release lag
        ext_val[6] <= 1'b0;
        wr(0, OFF_CFG, 8'h70);
        repeat (20 * TK) @(posedge clock);
        ext_val[6] <= 1'b1;
        repeat (3 * TK) @(posedge clock);
        ext_val[6] <= 1'b0;
        wait_ev(20 * TK, 1'b1);
        chk("glitch", 8'h00, {7'h00, wake_event[6]});
        ext_val[6] <= 1'b1;
        wait_ev(20 * TK, 1'b1);
        chk("deb on", 8'h01, {7'h00, n inside {[13*TK:16*TK+4]}});
        ext_val[6] <= 1'b0;
        wait_ev(20 * TK, 1'b0);
        chk("deb off", 8'h01, {7'h00, n inside {[13*TK:16*TK+4]}});
    endtask

    task automatic tally_and_finish;
        $display("comparisons %0d mismatches %0d", cmp_count, miscompares);
        if (miscompares == 0 && cmp_count > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask

    initial begin
        repeat (4000) @(posedge clock);
        miscompares++;
        tally_and_finish();
    end

    initial begin
        repeat (6) @(posedge clock);
        rst <= 1'b0;
        t_reset();
        t_drive();
        t_lock();
        t_inactive();
        t_events();
        tally_and_finish();
    end
endmodule
